// File: design/wck_pkg.sv
// constants, types and helpers for the word clock port controller
// assumes a single 200 MHz bus clock and a 32-bit ahb-lite register bus
package wck_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int RATE_32K_HZ = 32000;
    localparam int RATE_44K1_HZ = 44100;
    localparam int RATE_48K_HZ = 48000;
    localparam int PER_W = 16;

    // single-speed word periods in bus clock cycles, rounded to nearest
    localparam logic [15:0] PER_32K = 16'((CLK_HZ + RATE_32K_HZ / 2) / RATE_32K_HZ);
    localparam logic [15:0] PER_44K1 = 16'((CLK_HZ + RATE_44K1_HZ / 2) / RATE_44K1_HZ);
    localparam logic [15:0] PER_48K = 16'((CLK_HZ + RATE_48K_HZ / 2) / RATE_48K_HZ);
    localparam logic [15:0] MID_32_44 = 16'((32'(PER_32K) + 32'(PER_44K1)) / 2);
    localparam logic [15:0] MID_44_48 = 16'((32'(PER_44K1) + 32'(PER_48K)) / 2);

    // acceptance window and speed classes for a measured period
    localparam logic [15:0] PER_MIN = 16'h0384;
    localparam logic [15:0] PER_MAX = 16'h1b58;
    localparam logic [15:0] PER_SINGLE_MIN = 16'h0e10;
    localparam logic [15:0] PER_DOUBLE_MIN = 16'h06a4;
    localparam logic [15:0] SYNC_TOL = 16'h0004;

    // master clock ticks per word period (about 22.6 MHz at 44.1 kHz)
    localparam logic [15:0] MCLK_MULT = 16'h0200;

    // missing-edge timeout
    localparam int TIMEOUT_US = 100;
    localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PITCH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PERIOD = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;

    // control field positions and reset value
    localparam int CTRL_REF_WC = 0;
    localparam int CTRL_TERM = 1;
    localparam int CTRL_SINGLE = 2;
    localparam int CTRL_RATE_LSB = 4;
    localparam int CTRL_SPEED_LSB = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0010;

    // status field positions
    localparam int ST_VALID = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_SYNC = 2;
    localparam int ST_SPEED_LSB = 4;
    localparam int ST_SLAVE = 6;
    localparam int ST_FALLBACK = 7;

    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_LOCK = 0;
    localparam int IRQ_LOST = 1;
    localparam int IRQ_SPEED = 2;

    typedef enum logic [1:0] {WCK_R32, WCK_R441, WCK_R48} wck_rate_t;
    typedef enum logic [1:0] {WCK_SINGLE, WCK_DOUBLE, WCK_QUAD} wck_speed_t;

    function automatic logic [15:0] rate_period(input wck_rate_t r);
        case (r)
            WCK_R32: rate_period = PER_32K;
            WCK_R48: rate_period = PER_48K;
            default: rate_period = PER_44K1;
        endcase
    endfunction : rate_period

    function automatic wck_speed_t speed_of(input logic [15:0] per);
        if (per >= PER_SINGLE_MIN) speed_of = WCK_SINGLE;
        else if (per >= PER_DOUBLE_MIN) speed_of = WCK_DOUBLE;
        else speed_of = WCK_QUAD;
    endfunction : speed_of

    function automatic wck_rate_t nearest_rate(input logic [15:0] base_per);
        if (base_per > MID_32_44) nearest_rate = WCK_R32;
        else if (base_per > MID_44_48) nearest_rate = WCK_R441;
        else nearest_rate = WCK_R48;
    endfunction : nearest_rate

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff
endpackage : wck_pkg

// File: design/wck_meas_if.sv
// carries the input period measurement from the meter to the controller
// assumes both ends sit on the bus clock
`timescale 1ns/10ps
interface wck_meas_if;
    logic [15:0] per;
    logic valid;
    logic edge_seen;
    modport meter (output per, output valid, output edge_seen);
    modport user (input per, input valid, input edge_seen);
endinterface : wck_meas_if

// File: design/wck_period_meter.sv
// measures the word clock input period and judges it valid
// assumes wc_in is already synchronous to hclk
`timescale 1ns/10ps
module wck_period_meter #(
    parameter logic [15:0] TIMEOUT = 16'(wck_pkg::TIMEOUT_CYC)
) (
    input wire logic hclk,       // bus clock
    input wire logic hresetn,    // async reset, low
    input wire logic wc_in,      // word clock input level
    wck_meas_if.meter m          // measurement out
);
    typedef struct packed {
        logic prev;
        logic seen;
        logic [15:0] cnt;
        logic [15:0] per;
        logic valid;
        logic edge_seen;
    } wck_meter_st_t;

    wck_meter_st_t q_r, q_nxt;

    always_comb begin
        q_nxt = q_r;
        q_nxt.prev = wc_in;
        q_nxt.edge_seen = 1'b0;
        if (wc_in && !q_r.prev) begin
            q_nxt.edge_seen = 1'b1;
            q_nxt.cnt = 16'h0001;
            q_nxt.seen = 1'b1;
            q_nxt.valid = q_r.seen && q_r.cnt >= wck_pkg::PER_MIN && q_r.cnt <= wck_pkg::PER_MAX;
            if (q_nxt.valid) begin
                q_nxt.per = q_r.cnt;
            end
        end else begin
            if (q_r.cnt != 16'hffff) begin
                q_nxt.cnt = q_r.cnt + 16'h0001;
            end
            if (q_r.cnt >= TIMEOUT) begin
                q_nxt.valid = 1'b0;
                q_nxt.seen = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) q_r <= '0;
        else q_r <= q_nxt;
    end

    assign m.per = q_r.per;
    assign m.valid = q_r.valid;
    assign m.edge_seen = q_r.edge_seen;

    a_timeout_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.cnt >= TIMEOUT && !(wc_in && !q_r.prev)) |=> !q_r.valid)
        else $error("validity held past the edge timeout");
endmodule : wck_period_meter

// File: design/wck_tick_gen.sv
// fractional divider: MCLK_MULT ticks per word period
// assumes period stays above MCLK_MULT, true for every accepted rate
`timescale 1ns/10ps
module wck_tick_gen (
    input wire logic hclk,          // bus clock
    input wire logic hresetn,       // async reset, low
    input wire logic [15:0] per,    // word period in cycles
    input wire logic phase,         // realign pulse at a reference edge
    output logic tick               // one-cycle master clock tick
);
    typedef struct packed {
        logic [16:0] acc;
        logic tick;
        logic [15:0] seen;
        logic [15:0] wcnt;
    } wck_tick_st_t;

    wck_tick_st_t q_r, q_nxt;
    logic [16:0] sum;

    always_comb begin
        q_nxt = q_r;
        // realign to the reference so ticks stay phase tied
        // realign cycle still takes its step, else each period loses a tick
        sum = (phase ? 17'h00000 : q_r.acc) + {1'b0, wck_pkg::MCLK_MULT};
        q_nxt.tick = 1'b0;
        if (sum >= {1'b0, per}) begin
            q_nxt.acc = sum - {1'b0, per};
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.acc = sum;
        end
        // one word period window, so the count check also holds as master
        if (phase || q_r.wcnt >= per - 16'h0001) begin
            q_nxt.wcnt = 16'h0000;
            q_nxt.seen = {15'h0000, q_nxt.tick};
        end else begin
            q_nxt.wcnt = q_r.wcnt + 16'h0001;
            q_nxt.seen = q_r.seen + {15'h0000, q_nxt.tick};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) q_r <= '0;
        else q_r <= q_nxt;
    end

    assign tick = q_r.tick;

    a_tick_count: assert property (@(posedge hclk) disable iff (!hresetn)
        q_r.seen <= wck_pkg::MCLK_MULT + 16'h0001)
        else $error("too many master ticks in one word period");
endmodule : wck_tick_gen

// File: design/wck_port_ctrl.sv
// word clock port controller: reference selection, rate detection, output
// assumes ahb-lite single word transfers and wc_in synchronous to hclk
//
// What this block does
// - The word clock input is the reference only while software selects it and a valid signal is present.
// - Single, double or quad speed of the input is recognised by its period without software help.
// - With a valid reference present, lock and sync status bits are readable by software.
// - A software bit drives the 75 ohm termination switch, off after reset.
// - The word clock output always toggles as a square wave at the active rate, or at its base rate with single speed set.
// - As master, the output period comes from the software rate and speed plus the pitch offset.
// - As slave, the output follows the frequency of the selected input.
// - On reference loss the block turns master at the nearest standard rate of the lost signal.
// - With single speed set, the output is divided down into the 32 to 48 kHz range.
// - As slave, the output rises on the input rising edge, in phase.
// - A master clock tick stream of 512 ticks per word period is regenerated from the reference.
`timescale 1ns/10ps
module wck_port_ctrl #(
    parameter int TIMEOUT_CYC = wck_pkg::TIMEOUT_CYC
) (
    input wire logic hclk,            // bus clock, 200 MHz
    input wire logic hresetn,         // async reset, low
    input wire logic hsel,            // slave select
    input wire logic [31:0] haddr,    // byte address
    input wire logic [1:0] htrans,    // transfer type
    input wire logic hwrite,          // write when high
    input wire logic [2:0] hsize,     // transfer size
    input wire logic [31:0] hwdata,   // write data
    input wire logic hready,          // bus ready
    output logic hreadyout,           // slave ready
    output logic [31:0] hrdata,       // read data
    output logic hresp,               // always okay
    input wire logic wc_in,           // word clock input
    output logic wc_out,              // word clock output
    output logic wc_term_en,          // 75 ohm termination switch
    output logic mclk_tick,           // regenerated master clock tick
    output logic irq                  // level interrupt
);
    typedef struct packed {
        logic hready;
        logic a_sel;
        logic a_wr;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic ref_wc;
        logic term;
        logic single;
        wck_pkg::wck_rate_t rate;
        wck_pkg::wck_speed_t speed;
        logic [15:0] pitch;
        logic lock;
        logic sync;
        wck_pkg::wck_speed_t det_speed;
        logic slave;
        logic fallback;
        wck_pkg::wck_rate_t fb_rate;
        wck_pkg::wck_speed_t fb_speed;
        logic wc_out;
        logic [15:0] ocnt;
        logic [1:0] ediv;
        logic [wck_pkg::IRQ_W-1:0] istat;
        logic [wck_pkg::IRQ_W-1:0] imask;
        logic irq;
    } wck_ctrl_st_t;

    wck_ctrl_st_t q_r, q_nxt;
    wck_meas_if meas ();

    logic wr_now;
    logic [31:0] rd_val;
    logic [31:0] st_word;
    wck_pkg::wck_rate_t m_rate;
    wck_pkg::wck_speed_t m_speed;
    wck_pkg::wck_speed_t act_speed;
    logic [15:0] m_per;
    logic [15:0] act_per;
    logic [15:0] out_per;
    logic [1:0] div_mask;
    logic [wck_pkg::IRQ_W-1:0] ev;
    logic [wck_pkg::IRQ_W-1:0] clr;

    wck_period_meter #(.TIMEOUT(16'(TIMEOUT_CYC))) u_meter (
        .hclk(hclk),
        .hresetn(hresetn),
        .wc_in(wc_in),
        .m(meas.meter)
    );

    wck_tick_gen u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .per(act_per),
        .phase(q_r.slave && meas.edge_seen),
        .tick(mclk_tick)
    );

    always_comb begin
        q_nxt = q_r;
        ev = '0;
        clr = '0;
        wr_now = q_r.a_sel && q_r.a_wr;

        // master rate: software setting, or the fallback choice after a loss
        m_rate = q_r.fallback ? q_r.fb_rate : q_r.rate;
        m_speed = q_r.fallback ? q_r.fb_speed : q_r.speed;
        // period from rate, speed and pitch offset
        m_per = 16'((wck_pkg::rate_period(m_rate) >> m_speed) + q_r.pitch);
        // slave period is the measured input period
        act_per = q_r.slave ? meas.per : m_per;
        act_speed = q_r.slave ? q_r.det_speed : m_speed;
        // single speed stretches the output back to base rate
        out_per = q_r.single ? 16'(act_per << act_speed) : act_per;
        div_mask = q_r.single ? 2'((3'h1 << act_speed) - 3'h1) : 2'h0;

        st_word = '0;
        st_word[wck_pkg::ST_VALID] = meas.valid;
        st_word[wck_pkg::ST_LOCK] = q_r.lock;
        st_word[wck_pkg::ST_SYNC] = q_r.sync;
        st_word[wck_pkg::ST_SPEED_LSB +: 2] = q_r.det_speed;
        st_word[wck_pkg::ST_SLAVE] = q_r.slave;
        st_word[wck_pkg::ST_FALLBACK] = q_r.fallback;

        rd_val = '0;
        case (haddr[7:0])
            wck_pkg::REG_CTRL: begin
                rd_val[wck_pkg::CTRL_REF_WC] = q_r.ref_wc;
                rd_val[wck_pkg::CTRL_TERM] = q_r.term;
                rd_val[wck_pkg::CTRL_SINGLE] = q_r.single;
                rd_val[wck_pkg::CTRL_RATE_LSB +: 2] = q_r.rate;
                rd_val[wck_pkg::CTRL_SPEED_LSB +: 2] = q_r.speed;
            end
            wck_pkg::REG_PITCH: rd_val[15:0] = q_r.pitch;
            wck_pkg::REG_STATUS: rd_val = st_word;
            wck_pkg::REG_PERIOD: rd_val[15:0] = meas.per;
            wck_pkg::REG_IRQ_STAT: rd_val[wck_pkg::IRQ_W-1:0] = q_r.istat;
            wck_pkg::REG_IRQ_MASK: rd_val[wck_pkg::IRQ_W-1:0] = q_r.imask;
            default: rd_val = '0;
        endcase

        // address phase; zero wait so read data is registered here
        q_nxt.hready = 1'b1;
        q_nxt.a_sel = hsel && htrans[1] && hready && hsize == 3'b010;
        q_nxt.a_wr = hwrite;
        q_nxt.a_addr = haddr[7:0];
        if (q_nxt.a_sel && !hwrite) begin
            q_nxt.hrdata = rd_val;
        end

        // data phase writes
        if (wr_now) begin
            case (q_r.a_addr)
                wck_pkg::REG_CTRL: begin
                    q_nxt.ref_wc = hwdata[wck_pkg::CTRL_REF_WC];
                    q_nxt.term = hwdata[wck_pkg::CTRL_TERM];
                    q_nxt.single = hwdata[wck_pkg::CTRL_SINGLE];
                    q_nxt.rate = wck_pkg::wck_rate_t'(hwdata[wck_pkg::CTRL_RATE_LSB +: 2]);
                    q_nxt.speed = wck_pkg::wck_speed_t'(hwdata[wck_pkg::CTRL_SPEED_LSB +: 2]);
                    // a fresh software setting ends the fallback
                    q_nxt.fallback = 1'b0;
                end
                wck_pkg::REG_PITCH: q_nxt.pitch = hwdata[15:0];
                wck_pkg::REG_IRQ_STAT: clr = hwdata[wck_pkg::IRQ_W-1:0];
                wck_pkg::REG_IRQ_MASK: q_nxt.imask = hwdata[wck_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end

        // speed class from each accepted period
        if (meas.edge_seen && meas.valid) begin
            q_nxt.det_speed = wck_pkg::speed_of(meas.per);
            ev[wck_pkg::IRQ_SPEED] = q_nxt.det_speed != q_r.det_speed;
        end

        // slave only when selected and valid
        q_nxt.slave = q_r.ref_wc && meas.valid;
        if (q_nxt.slave) begin
            q_nxt.fallback = 1'b0;
        end
        // loss: master at nearest standard rate of the lost signal
        if (q_r.slave && !meas.valid) begin
            q_nxt.fallback = 1'b1;
            q_nxt.fb_rate = wck_pkg::nearest_rate(16'(meas.per << q_r.det_speed));
            q_nxt.fb_speed = q_r.det_speed;
            ev[wck_pkg::IRQ_LOST] = 1'b1;
        end

        // lock on a valid input, sync when it matches the active rate
        q_nxt.lock = meas.valid;
        q_nxt.sync = meas.valid && wck_pkg::abs_diff(meas.per, act_per) <= wck_pkg::SYNC_TOL;
        ev[wck_pkg::IRQ_LOCK] = meas.valid && !q_r.lock;

        // output generator, running in every mode
        if (q_r.slave) begin
            if (meas.edge_seen) begin
                // output rises with every kept input edge
                q_nxt.ediv = (q_r.ediv + 2'h1) & div_mask;
                // masked: a stale divider phase after single speed is cleared
                if ((q_r.ediv & div_mask) == 2'h0) begin
                    q_nxt.wc_out = 1'b1;
                    q_nxt.ocnt = 16'h0001;
                end else begin
                    q_nxt.ocnt = q_r.ocnt + 16'h0001;
                end
            end else begin
                q_nxt.ocnt = (q_r.ocnt == 16'hffff) ? q_r.ocnt : q_r.ocnt + 16'h0001;
                if (q_r.ocnt >= (out_per >> 1)) begin
                    q_nxt.wc_out = 1'b0;
                end
            end
        end else begin
            q_nxt.ediv = 2'h0;
            if (q_r.ocnt >= out_per - 16'h0001) begin
                q_nxt.ocnt = 16'h0000;
                q_nxt.wc_out = 1'b1;
            end else begin
                q_nxt.ocnt = q_r.ocnt + 16'h0001;
                q_nxt.wc_out = q_nxt.ocnt < (out_per >> 1);
            end
        end

        // sticky status: a new event beats a same-cycle clear
        q_nxt.istat = (q_r.istat & ~clr) | ev;
        q_nxt.irq = |(q_nxt.istat & q_nxt.imask);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= '0;
            q_r.hready <= 1'b1;
            q_r.rate <= wck_pkg::wck_rate_t'(wck_pkg::CTRL_RESET[wck_pkg::CTRL_RATE_LSB +: 2]);
        end else begin
            q_r <= q_nxt;
        end
    end

    assign hreadyout = q_r.hready;
    assign hrdata = q_r.hrdata;
    assign hresp = 1'b0;
    assign wc_out = q_r.wc_out;
    assign wc_term_en = q_r.term;
    assign irq = q_r.irq;

    // helper: cycles since the output last changed
    logic [17:0] still_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) still_r <= '0;
        else if (q_nxt.wc_out != q_r.wc_out) still_r <= '0;
        else if (still_r != 18'h3ffff) still_r <= still_r + 18'h00001;
    end

    a_ref_select: assert property (@(posedge hclk) disable iff (!hresetn)
        q_r.slave |-> $past(q_r.ref_wc) && $past(meas.valid))
        else $error("slave mode without selection and valid input");
    a_speed_class: assert property (@(posedge hclk) disable iff (!hresetn)
        (meas.edge_seen && meas.valid && meas.per < wck_pkg::PER_DOUBLE_MIN) |=> q_r.det_speed == wck_pkg::WCK_QUAD)
        else $error("short period not classed as quad speed");
    a_status_pair: assert property (@(posedge hclk) disable iff (!hresetn)
        q_r.sync |-> q_r.lock)
        else $error("sync reported without lock");
    a_term_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && q_r.a_addr == wck_pkg::REG_CTRL) |=> wc_term_en == $past(hwdata[wck_pkg::CTRL_TERM]))
        else $error("termination does not follow control write");
    a_out_alive: assert property (@(posedge hclk) disable iff (!hresetn)
        still_r < 18'h20000)
        else $error("word clock output stuck");
    a_master_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (!q_r.slave && !q_nxt.slave && q_r.ocnt >= out_per - 16'h0001) |=> wc_out && q_r.ocnt == 16'h0000)
        else $error("master output period wrong");
    a_slave_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.slave && meas.edge_seen && q_r.ediv == 2'h0) |=> $rose(wc_out) || $past(wc_out))
        else $error("slave output not in phase with input");
    a_slave_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.slave && !q_r.single && meas.edge_seen) |=> q_r.ocnt == 16'h0001)
        else $error("slave output not restarted by input edge");
    a_fallback_master: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.slave && !meas.valid) |=> q_r.fallback && !q_r.slave)
        else $error("no fallback to master after loss");
    a_single_div: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.single && q_r.slave && q_r.det_speed == wck_pkg::WCK_QUAD) |-> div_mask == 2'h3)
        else $error("single speed divider wrong for quad");
    a_loss_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(meas.valid) |=> !q_r.lock && !q_r.sync)
        else $error("status held after loss");
endmodule : wck_port_ctrl

// File: tb/wck_src_model.sv
// word clock source standing in for an external clock master
// assumes it runs off the bench's hclk
`timescale 1ns/10ps
module wck_src_model (
    input wire logic hclk,       // bench clock
    input wire logic run,        // source enabled
    input wire logic [15:0] per, // word period in cycles
    output logic wc              // word clock line
);
    logic [15:0] cnt_r;
    // terminated idle line rests low, so a stopped source reads 0
    always_ff @(posedge hclk) begin
        if (!run) begin
            cnt_r <= 16'h0000;
            wc <= 1'b0;
        end else begin
            cnt_r <= (cnt_r >= per - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
            wc <= (cnt_r < (per >> 1));
        end
    end
endmodule : wck_src_model

// File: tb/tb_word_clock_port_control.sv
// bench for the word clock port controller over ahb-lite
// assumes a 200 MHz hclk and an external source model on wc_in
`timescale 1ns/10ps
module tb_word_clock_port_control;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic run = 1'b0;
    logic wo_q = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, wc_in, wc_out, wc_term_en, mclk_tick, irq;
    logic [31:0] hrdata, rd, per_seen, ticks_seen;
    logic [31:0] cyc = 32'h0;
    logic [31:0] ticks = 32'h0;
    logic [31:0] tbl_c [4] = '{32'h40, 32'h60, 32'ha0, 32'ha4};
    logic [31:0] tbl_p [4] = '{32'h0c35, 32'h0823, 32'h0411, 32'h1044};
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int n_ph;

    always #2.5 hclk = ~hclk;

    wck_port_ctrl #(.TIMEOUT_CYC(8000)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .wc_in(wc_in), .wc_out(wc_out), .wc_term_en(wc_term_en), .mclk_tick(mclk_tick), .irq(irq));
    wck_src_model src (.hclk(hclk), .run(run), .per(16'h07d0), .wc(wc_in));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // output period and tick count between successive wc_out rises
    always @(posedge hclk) begin
        wo_q <= wc_out;
        n_cyc = n_cyc + 1;
        if (wc_out === 1'b1 && wo_q === 1'b0) begin
            per_seen <= cyc;
            ticks_seen <= ticks;
            cyc <= 32'h1;
            ticks <= {31'h0, mclk_tick};
        end else begin
            cyc <= cyc + 32'h1;
            ticks <= ticks + {31'h0, mclk_tick};
        end
        if (n_cyc == 110000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // first two rises may straddle a setting change, so skip them
    task automatic meas(input logic [31:0] exp);
        repeat (3) @(posedge wc_out);
        @(posedge hclk);
        #1;
        chk(per_seen, exp);
    endtask : meas

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(8'h00, 32'h10);
        rdchk(8'h14, 32'h0);
        rdchk(8'h20, 32'h0);
        chk({31'h0, wc_term_en}, 32'h0);
        xfer(8'h00, 1'b1, 32'h12);
        @(posedge hclk);
        chk({31'h0, wc_term_en}, 32'h1);
        xfer(8'h00, 1'b1, 32'h10);
        meas(32'h11b7);
        xfer(8'h04, 1'b1, 32'hfff6);
        meas(32'h11ad);
        xfer(8'h04, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(8'h00, 1'b1, tbl_c[i]);
            meas(tbl_p[i]);
        end
        xfer(8'h00, 1'b1, 32'h10);
        run <= 1'b1;
        meas(32'h11b7);
        rdchk(8'h08, 32'h13);
        rdchk(8'h0c, 32'h07d0);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        xfer(8'h10, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h1);
        xfer(8'h14, 1'b1, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(8'h10, 1'b1, 32'h7);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        xfer(8'h00, 1'b1, 32'h11);
        meas(32'h07d0);
        chk(ticks_seen, 32'h200);
        rdchk(8'h08, 32'h57);
        @(posedge wc_in);
        n_ph = 0;
        while (wc_out !== 1'b1 && n_ph < 8) begin
            @(posedge hclk);
            n_ph++;
        end
        chk({31'h0, n_ph <= 5}, 32'h1);
        xfer(8'h00, 1'b1, 32'h15);
        meas(32'h0fa0);
        xfer(8'h00, 1'b1, 32'h11);
        run <= 1'b0;
        repeat (9000) @(posedge hclk);
        xfer(8'h08, 1'b0, 32'h0);
        chk(rd & 32'hc7, 32'h80);
        chk({31'h0, irq}, 32'h1);
        meas(32'h0823);
        tally_and_finish();
    end
endmodule : tb_word_clock_port_control
